/* File: src/dis_regs.svh */
/*
  Constants of the debounced input serializer: frame layout,
  debounce timing and register offsets.
  Assumes inclusion by bare name from the package; the design module uses its macros without including it.
*/
// Operation
// [RULE_01] a new field level is accepted only after staying stable the whole interval
// [RULE_02] filter selects: both open 3 ms, low grounded 1 ms, high grounded bypass
// [RULE_03] while capture strobe low, register continuously takes debounced states and flags
// [RULE_04] capture strobe high blocks parallel capture; contents held apart from shifting
// [RULE_05] shift one place per rising serial clock while strobe high and gate low
// [RULE_06] strobe high and gate high: clock edges change neither register nor output
// [RULE_07] each shift moves stages toward output; serial input enters first stage
// [RULE_08] frame of eleven: parity, undervoltage, overtemp, channels 0 to 7, seven last
// [RULE_09] after eleven enabled shifts the frame is gone; serial input data follows
// [RULE_10] parity is recomputed whenever a channel, undervoltage or overtemp status changes
// [RULE_11] temperature at first trip drives the low-active overtemp output low
// [RULE_12] temperature past second trip puts every device output in high impedance; code floats only serial out and overtemp flag, not REG_RDATA_O or IRQ_O
// [RULE_13] while tri-stated by heat, a pull-down holds the overtemp output low
// [RULE_14] cascading wires serial output to next serial input, sharing strobe, gate, clock
// [RULE_15] paralleled field inputs are read by the controller as one channel of two bits
// [RULE_16] parity makes the count of ones over the eleven-bit frame odd
// [RULE_17] undervoltage and overtemp bits follow their monitors, sampled at each load
`ifndef DIS_REGS_SVH
`define DIS_REGS_SVH

`define DIS_FRAME_W 11
`define DIS_CHAN_N 8
`define DIS_POS_PARITY 10
`define DIS_POS_SUPPLY 9
`define DIS_POS_OVERTEMP 8

`define DIS_CLK_MHZ 250
`define DIS_DB_LONG_MS 3
`define DIS_DB_SHORT_MS 1
`define DIS_DB_LONG_CYC (`DIS_DB_LONG_MS * 1000 * `DIS_CLK_MHZ)
`define DIS_DB_SHORT_CYC (`DIS_DB_SHORT_MS * 1000 * `DIS_CLK_MHZ)

`define DIS_REG_STATUS 4'h0
`define DIS_REG_MASK 4'h4
`define DIS_REG_STATE 4'h8
`define DIS_MASK_RST 8'h00

`endif

/* File: src/dis_pkg.sv */
/*
  Types of the debounced input serializer.
  Assumes dis_regs.svh is reachable by bare name.
*/
`include "dis_regs.svh"
package dis_pkg;
  typedef logic [`DIS_FRAME_W-1:0] dis_frame_t;
  typedef logic [`DIS_CHAN_N-1:0] dis_chan_t;
  typedef enum logic [1:0]
  {
    DIS_DB_BYPASS = 2'h0,
    DIS_DB_SHORT = 2'h1,
    DIS_DB_LONG = 2'h2,
    DIS_DB_RSVD = 2'h3
  } dis_db_mode_t;
  typedef struct packed
  {
    logic capture_strobe_n;
    logic shift_gate_n;
    logic serial_clk;
    logic serial_shift_in;
  } dis_link_t;
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dis_bus_t;
endpackage

/* File: src/dis_debounce.sv */
/*
  Holds no logic: the per-channel debounce filter is a generate loop in dis_top.
  Assumes nothing of its surroundings.
*/

/* File: src/dis_top.sv */
/*
  Debounced input serializer: eight filtered field inputs and two monitor
  flags form an eleven-bit odd-parity frame in a shift register, read by an
  external controller over strobe, gate and serial clock pins.
  Assumes link, field and monitor pins asynchronous to REF_CLK_I, the register bus synchronous; the serial clock
  must be well below a quarter of REF_CLK_I.
*/
module dis_top
  import dis_pkg::*;
#(
  parameter int DB_LONG_CYC = `DIS_DB_LONG_CYC,
  parameter int DB_SHORT_CYC = `DIS_DB_SHORT_CYC
)
(
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] FIELD_CHANNEL_INPUTS_I,
  input wire logic FILTER_SELECT_LOW_I,
  input wire logic FILTER_SELECT_HIGH_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic TEMP_TRIP1_I,
  input wire logic TEMP_TRIP2_I,
  input wire logic CAPTURE_STROBE_N_I,
  input wire logic SHIFT_GATE_N_I,
  input wire logic SERIAL_CLK_I,
  input wire logic SERIAL_SHIFT_IN_I,
  output logic SERIAL_SHIFT_OUT_O,
  output logic SERIAL_SHIFT_OUT_OE_O,
  output logic OVERTEMP_FLAG_N_O,
  output logic OVERTEMP_FLAG_N_OE_O,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic IRQ_O
);
  import dis_pkg::*;

  localparam int CNT_W = 20;

  // pin synchronisers; stage one is read by stage two only
  logic [14:0] pin_s1_r;
  logic [14:0] pin_s2_r;
  logic [14:0] pin_raw;
  dis_link_t link;
  dis_chan_t chan_sync;
  logic sclk_d_r;
  logic sclk_rise;

  assign pin_raw = {FIELD_CHANNEL_INPUTS_I, FILTER_SELECT_HIGH_I, FILTER_SELECT_LOW_I,
                    SUPPLY_LOW_I, CAPTURE_STROBE_N_I, SHIFT_GATE_N_I, SERIAL_CLK_I,
                    SERIAL_SHIFT_IN_I};

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      pin_s1_r <= 15'h000F;
      pin_s2_r <= 15'h000F;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign chan_sync = pin_s2_r[14:7];
  assign link = pin_s2_r[3:0];

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      sclk_d_r <= 1'b1;
    else
      sclk_d_r <= link.serial_clk;
  end

  assign sclk_rise = link.serial_clk && !sclk_d_r;

  // temperature trips synchronised separately, since they gate the pins
  logic [1:0] temp_s1_r;
  logic [1:0] temp_s2_r;
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      temp_s1_r <= 2'h0;
      temp_s2_r <= 2'h0;
    end
    else
    begin
      temp_s1_r <= {TEMP_TRIP2_I, TEMP_TRIP1_I};
      temp_s2_r <= temp_s1_r;
    end
  end

  // filter select; an open pin reads high
  dis_db_mode_t db_mode;
  logic [CNT_W-1:0] db_limit;
  logic db_bypass;

  always_comb
  begin
    case (pin_s2_r[6:5]) // [RULE_02]
      2'h3: db_mode = DIS_DB_LONG;
      2'h2: db_mode = DIS_DB_SHORT;
      2'h1: db_mode = DIS_DB_BYPASS;
      default: db_mode = DIS_DB_RSVD;
    endcase
  end

  always_comb
  begin
    db_bypass = 1'b0;
    case (db_mode)
      DIS_DB_LONG: db_limit = CNT_W'(DB_LONG_CYC);
      DIS_DB_SHORT: db_limit = CNT_W'(DB_SHORT_CYC);
      DIS_DB_BYPASS:
      begin
        db_limit = CNT_W'(1);
        db_bypass = 1'b1;
      end
      // reserved code: treated as the longest filter, the safe side
      default: db_limit = CNT_W'(DB_LONG_CYC);
    endcase
  end

  // per-channel filter: a new level must hold for db_limit samples;
  // a shorter limit picked mid-count cuts the wait short, never stretches it
  dis_chan_t chan_clean;
  genvar gi;
  generate
    for (gi = 0; gi < `DIS_CHAN_N; gi++)
    begin : g_db
      logic [CNT_W-1:0] cnt_r;
      logic clean_r;

      always_ff @(posedge REF_CLK_I)
      begin
        if (SRST_I)
          cnt_r <= '0;
        else if (db_bypass || chan_sync[gi] == clean_r)
          cnt_r <= '0; // bounce back restarts the wait
        else if (cnt_r >= db_limit - 1'b1)
          cnt_r <= '0;
        else
          cnt_r <= cnt_r + 1'b1;
      end

      always_ff @(posedge REF_CLK_I)
      begin
        if (SRST_I)
          clean_r <= 1'b0;
        else if (db_bypass)
          clean_r <= chan_sync[gi];
        else if (chan_sync[gi] != clean_r && cnt_r >= db_limit - 1'b1)
          clean_r <= chan_sync[gi]; // [RULE_01]
      end

      assign chan_clean[gi] = clean_r;
    end
  endgenerate

  // parallel frame; parity follows every status change
  logic supply_low;
  logic overtemp;
  dis_frame_t frame_in;
  dis_chan_t chan_rev;

  assign supply_low = pin_s2_r[4]; // [RULE_17]
  assign overtemp = temp_s2_r[0]; // [RULE_17]

  always_comb
  begin
    for (int i = 0; i < `DIS_CHAN_N; i++)
      chan_rev[i] = chan_clean[`DIS_CHAN_N-1-i];
  end

  always_comb
  begin
    frame_in = '0;
    frame_in[`DIS_CHAN_N-1:0] = chan_rev; // [RULE_08]
    frame_in[`DIS_POS_OVERTEMP] = overtemp;
    frame_in[`DIS_POS_SUPPLY] = supply_low;
    frame_in[`DIS_POS_PARITY] = ~^{supply_low, overtemp, chan_clean}; // [RULE_10] [RULE_16]
  end

  // shift register; stage 0 is the first stage, MSB drives the output
  dis_frame_t shreg_r;
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      shreg_r <= '0;
    else if (!link.capture_strobe_n)
      shreg_r <= frame_in; // [RULE_03]
    else if (sclk_rise && !link.shift_gate_n) // [RULE_04] [RULE_05] [RULE_06]
      shreg_r <= {shreg_r[`DIS_FRAME_W-2:0], link.serial_shift_in}; // [RULE_07] [RULE_09]
  end

  // output pins and thermal behaviour
  logic shutdown;
  assign shutdown = temp_s2_r[1] | temp_s2_r[0] & temp_s2_r[1];

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      SERIAL_SHIFT_OUT_O <= 1'b0;
    else
      SERIAL_SHIFT_OUT_O <= shreg_r[`DIS_FRAME_W-1];
  end

  // past the second trip both pins float; the flag value then shows
  // the level that the internal pull-down gives the floating pin
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      SERIAL_SHIFT_OUT_OE_O <= 1'b0;
      OVERTEMP_FLAG_N_O <= 1'b1;
      OVERTEMP_FLAG_N_OE_O <= 1'b0;
    end
    else
    begin
      SERIAL_SHIFT_OUT_OE_O <= !shutdown; // [RULE_12]
      OVERTEMP_FLAG_N_O <= shutdown ? 1'b0 : !overtemp; // [RULE_11] [RULE_13]
      OVERTEMP_FLAG_N_OE_O <= !shutdown; // [RULE_12]
    end
  end

  // interrupt status: bit0 supply low rise, bit1 overtemp rise,
  // bit2 shutdown rise, bit3 any clean channel change
  logic [3:0] ev;
  logic [3:0] evsrc_d_r;
  dis_chan_t chan_d_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic rd_stat;

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      evsrc_d_r <= 4'h0;
      chan_d_r <= '0;
    end
    else
    begin
      evsrc_d_r <= {1'b0, shutdown, overtemp, supply_low};
      chan_d_r <= chan_clean;
    end
  end

  assign ev = {(chan_clean != chan_d_r), shutdown & ~evsrc_d_r[2],
               overtemp & ~evsrc_d_r[1], supply_low & ~evsrc_d_r[0]};
  assign rd_stat = REG_RD_I && REG_ADDR_I == `DIS_REG_STATUS;

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      irq_stat_r <= 8'h00;
    else // set wins over the read-clear
      irq_stat_r <= (rd_stat ? 8'h00 : irq_stat_r) | {4'h0, ev};
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      irq_mask_r <= `DIS_MASK_RST;
    else if (REG_WR_I && REG_ADDR_I == `DIS_REG_MASK)
      irq_mask_r <= REG_WDATA_I;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      REG_RDATA_O <= 8'h00;
    else if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `DIS_REG_STATUS: REG_RDATA_O <= irq_stat_r;
        `DIS_REG_MASK: REG_RDATA_O <= irq_mask_r;
        `DIS_REG_STATE: REG_RDATA_O <= chan_clean;
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
    else
      REG_RDATA_O <= 8'h00;
  end

  assign IRQ_O = |(irq_stat_r & irq_mask_r);
endmodule

/* File: sim/dis_monitor.sv */
/*
  Port checker for dis_top, bound in at the foot of this file.
  Assumes one clock domain and the synchronous high reset.
*/
module dis_monitor
(
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic TEMP_TRIP1_I,
  input wire logic TEMP_TRIP2_I,
  input wire logic CAPTURE_STROBE_N_I,
  input wire logic SHIFT_GATE_N_I,
  input wire logic SERIAL_SHIFT_OUT_O,
  input wire logic SERIAL_SHIFT_OUT_OE_O,
  input wire logic OVERTEMP_FLAG_N_O,
  input wire logic OVERTEMP_FLAG_N_OE_O,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // eight quiet cycles outrun the pin synchronisers
  sequence s_frozen;
    (CAPTURE_STROBE_N_I && SHIFT_GATE_N_I && !TEMP_TRIP2_I) [*8];
  endsequence
  sequence s_shut;
    TEMP_TRIP2_I [*4];
  endsequence
  a_frozen_out: assert property (s_frozen |=> $stable(SERIAL_SHIFT_OUT_O))
    else $error("serial output moved while gated");
  a_hot_low: assert property (TEMP_TRIP1_I [*4] |=> !OVERTEMP_FLAG_N_O)
    else $error("overtemp flag not low");
  a_hot_clear: assert property ((!TEMP_TRIP1_I) [*4] |=> OVERTEMP_FLAG_N_O)
    else $error("overtemp flag stuck low");
  a_sop_off: assert property (s_shut |=> !SERIAL_SHIFT_OUT_OE_O)
    else $error("serial output driven in shutdown");
  a_hot_pull: assert property (s_shut |=> !OVERTEMP_FLAG_N_O && !OVERTEMP_FLAG_N_OE_O)
    else $error("overtemp flag not held low");
  a_sop_on: assert property ((!TEMP_TRIP2_I) [*4] |=> SERIAL_SHIFT_OUT_OE_O)
    else $error("serial output not driven");
  a_rd_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside read slot");
  a_rd_unmapped: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 4'hC
    |-> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind dis_top dis_monitor u_mon (
  .REF_CLK_I(REF_CLK_I),
  .SRST_I(SRST_I),
  .TEMP_TRIP1_I(TEMP_TRIP1_I),
  .TEMP_TRIP2_I(TEMP_TRIP2_I),
  .CAPTURE_STROBE_N_I(CAPTURE_STROBE_N_I),
  .SHIFT_GATE_N_I(SHIFT_GATE_N_I),
  .SERIAL_SHIFT_OUT_O(SERIAL_SHIFT_OUT_O),
  .SERIAL_SHIFT_OUT_OE_O(SERIAL_SHIFT_OUT_OE_O),
  .OVERTEMP_FLAG_N_O(OVERTEMP_FLAG_N_O),
  .OVERTEMP_FLAG_N_OE_O(OVERTEMP_FLAG_N_OE_O),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O)
);

/* File: sim/dis_mcu_model.sv */
/*
  Controller end of the serial link: loads, clocks out, feeds the chain input.
  Assumes one frame at a time, called from the bench.
*/
module dis_mcu_model
  import dis_pkg::*;
(
  input wire logic clk_i,
  input wire logic sout_i,
  output dis_link_t link_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'b0;
  initial link_o = 4'hC;
  // idle chain data toggles so no stale level can pass for data
  always @(posedge clk_i)
  begin
    if (!busy)
      link_o.serial_shift_in <= ~link_o.serial_shift_in;
  end
  task automatic pulse(input int half);
    repeat (half) @(posedge clk_i);
    link_o.serial_clk <= 1'b1;
    repeat (half) @(posedge clk_i);
    link_o.serial_clk <= 1'b0;
  endtask
  task automatic frame(input int half, input int hold, input logic [10:0] s,
                       output logic [21:0] rx);
    busy = 1'b1;
    link_o.capture_strobe_n <= 1'b0;
    link_o.shift_gate_n <= (hold == 0) ? 1'b0 : 1'b1;
    repeat (2) pulse(half);
    link_o.capture_strobe_n <= 1'b1;
    if (hold > 0)
    begin
      repeat (hold) pulse(half);
      link_o.shift_gate_n <= 1'b0;
    end
    repeat (half) @(posedge clk_i);
    for (int i = 0; i < 22; i++)
    begin
      rx[21 - i] = sout_i;
      link_o.serial_shift_in <= (i < 11) ? s[10 - i] : 1'b0;
      pulse(half);
    end
    link_o.shift_gate_n <= 1'b1;
    busy = 1'b0;
  endtask
endmodule

/* File: sim/debounced_input_serializer_tb_top.sv */
/*
  Bench of dis_top: filter modes, frames over the link, heat trips, registers.
  Assumes dis_pkg, dis_mcu_model and dis_monitor are compiled first.
*/
module debounced_input_serializer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dis_pkg::*;
  localparam int LONG = 30;
  localparam int SHORT = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dis_chan_t fld = 8'h00;
  logic [1:0] sel = 2'h3;
  logic uv = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  dis_bus_t bus = '0;
  dis_link_t lk;
  logic sop;
  logic sop_oe;
  logic hot_n;
  logic hot_oe;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] d;
  logic o1;
  logic o2;
  int bad_count = 0;
  int n_tests = 0;
  initial forever #2 clk = ~clk;
  dis_top #(.DB_LONG_CYC(LONG), .DB_SHORT_CYC(SHORT)) dut (
    .REF_CLK_I(clk),
    .SRST_I(rst),
    .FIELD_CHANNEL_INPUTS_I(fld),
    .FILTER_SELECT_LOW_I(sel[0]),
    .FILTER_SELECT_HIGH_I(sel[1]),
    .SUPPLY_LOW_I(uv),
    .TEMP_TRIP1_I(t1),
    .TEMP_TRIP2_I(t2),
    .CAPTURE_STROBE_N_I(lk.capture_strobe_n),
    .SHIFT_GATE_N_I(lk.shift_gate_n),
    .SERIAL_CLK_I(lk.serial_clk),
    .SERIAL_SHIFT_IN_I(lk.serial_shift_in),
    .SERIAL_SHIFT_OUT_O(sop),
    .SERIAL_SHIFT_OUT_OE_O(sop_oe),
    .OVERTEMP_FLAG_N_O(hot_n),
    .OVERTEMP_FLAG_N_OE_O(hot_oe),
    .REG_ADDR_I(bus.addr),
    .REG_WDATA_I(bus.wdata),
    .REG_WR_I(bus.wr),
    .REG_RD_I(bus.rd),
    .REG_RDATA_O(rdata),
    .IRQ_O(irq)
  );
  dis_mcu_model mcu (
    .clk_i(clk),
    .sout_i(sop),
    .link_o(lk)
  );
  task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle; read data lands in d
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  // overtemp and parity left zero: checked on their own
  function automatic dis_frame_t exp_frame(input dis_chan_t c, input logic u);
    dis_frame_t f;
    f = '0;
    f[9] = u;
    for (int i = 0; i < 8; i++)
      f[7 - i] = c[i];
    return f;
  endfunction
  task automatic run_frame(input int half, input int hold, output logic ot);
    logic [10:0] s;
    logic [21:0] rx;
    s = 11'($urandom);
    mcu.frame(half, hold, s, rx);
    check("frame", {exp_frame(fld, uv), s}, {rx[21:11] & 11'h2FF, rx[10:0]});
    check("parity", 22'h1, 22'(^rx[21:11]));
    if (hold == 2)
      check("paired", 22'(rx[18:11] & 8'h55), 22'((rx[18:11] >> 1) & 8'h55));
    ot = rx[19];
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #300us;
    bad_count++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test;
  end
  initial
  begin
    void'($urandom(73863));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      dis_chan_t was;
      int lim;
      was = fld;
      lim = (m == 1) ? 0 : (m == 2) ? SHORT : LONG;
      sel <= 2'(m);
      repeat (4) @(posedge clk);
      fld <= was ^ 8'($urandom | 1);
      if (lim > 0)
      begin
        repeat (lim - 4) @(posedge clk);
        xfer(1'b0, 4'h8, 8'h00);
        check("held", 22'(was), 22'(d));
      end
      repeat (LONG) @(posedge clk);
      xfer(1'b0, 4'h8, 8'h00);
      check("state", 22'(fld), 22'(d));
    end
    sel <= 2'h1;
    for (int k = 0; k < 6; k++)
    begin
      logic [7:0] p;
      p = 8'($urandom) & 8'h55;
      fld <= (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : (k % 3 == 2) ? (p | (p << 1)) : 8'($urandom);
      uv <= k[0];
      repeat (8) @(posedge clk);
      run_frame(8, k % 3, o1);
    end
    t1 <= 1'b1;
    repeat (8) @(posedge clk);
    run_frame(8, 1, o2);
    check("ot bit", 22'h1, 22'({o1, o2}));
    check("flag", 22'h0, 22'(hot_n));
    t2 <= 1'b1;
    repeat (8) @(posedge clk);
    check("shutdown", 22'h0, 22'({sop_oe, hot_n, hot_oe}));
    t2 <= 1'b0;
    t1 <= 1'b0;
    xfer(1'b0, 4'h0, 8'h00);
    check("events", 22'h0F, 22'(d));
    xfer(1'b1, 4'h4, 8'h08);
    fld <= ~fld;
    repeat (8) @(posedge clk);
    check("irq", 22'h1, 22'(irq));
    xfer(1'b0, 4'h4, 8'h00);
    check("mask", 22'h08, 22'(d));
    xfer(1'b0, 4'h0, 8'h00);
    check("status", 22'h08, 22'(d & 8'h08));
    xfer(1'b0, 4'h0, 8'h00);
    check("cleared", 22'h0, 22'({irq, d}));
    xfer(1'b1, 4'h4, 8'h00);
    fld <= ~fld;
    repeat (8) @(posedge clk);
    check("masked", 22'h0, 22'(irq));
    xfer(1'b0, 4'hC, 8'h00);
    check("unmapped", 22'h0, 22'(d));
    check("cooled", 22'h7, 22'({sop_oe, hot_n, hot_oe}));
    finish_test;
  end
endmodule
